// ==== canopen_ec_pkg.sv ====
// constants, types and helpers shared by both ends of the error-control link
// assumes a 25 MHz pclk and one data byte per error-control frame
package canopen_ec_pkg;
    // timing
    localparam int CLK_PERIOD_NS = 40;
    localparam int MS_NS = 1000000;
    localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
    localparam logic [15:0] HB_MARGIN_MS = 16'h0005;
    // frame identifiers and command specifiers
    localparam logic [10:0] ID_NMT = 11'h000;
    localparam logic [10:0] ID_ERR_CTRL = 11'h700;
    localparam logic [3:0] NMT_LEN = 4'h2;
    localparam logic [7:0] CS_START = 8'h01;
    localparam logic [7:0] CS_STOP = 8'h02;
    localparam logic [7:0] CS_PREOP = 8'h80;
    // state codes
    localparam logic [6:0] CODE_STOPPED = 7'h04;
    localparam logic [6:0] CODE_OP = 7'h05;
    localparam logic [6:0] CODE_PREOP = 7'h7f;
    localparam logic [7:0] HB_BOOT = 8'h00;
    localparam logic [7:0] HB_PREOP = 8'hff;
    // register offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_GUARD = 8'h04;
    localparam logic [7:0] REG_HB = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0c;
    localparam logic [7:0] REG_IRQ_STATUS = 8'h10;
    localparam logic [7:0] REG_IRQ_CLEAR = 8'h14;
    localparam logic [7:0] REG_IRQ_ENABLE = 8'h18;
    // field positions
    localparam int GUARD_LIFE_LSB = 16;
    localparam int STATUS_GUARD_ON = 8;
    localparam int STATUS_FAULT = 9;
    localparam int STATUS_TOGGLE = 10;
    localparam int IRQ_GUARD_ERR = 0;
    localparam int IRQ_STATE_CHG = 1;
    // reset values
    localparam logic [6:0] NODE_ID_RESET = 7'h01;
    localparam logic [15:0] GUARD_MS_RESET = 16'h0000;
    localparam logic [7:0] LIFE_RESET = 8'h00;
    localparam logic [15:0] HB_MS_RESET = 16'h0000;

    typedef enum logic [1:0] {NMT_BOOT, NMT_PREOP, NMT_OP, NMT_STOPPED} nmt_t;

    // seven-bit state code carried in a guarding answer
    function automatic logic [6:0] guard_code(input nmt_t s);
        unique case (s)
            NMT_STOPPED: guard_code = CODE_STOPPED;
            NMT_OP: guard_code = CODE_OP;
            default: guard_code = CODE_PREOP;
        endcase
    endfunction

    // byte carried in a heartbeat
    function automatic logic [7:0] hb_code(input nmt_t s);
        unique case (s)
            NMT_BOOT: hb_code = HB_BOOT;
            NMT_PREOP: hb_code = HB_PREOP;
            default: hb_code = {1'b0, guard_code(s)};
        endcase
    endfunction
endpackage

// ==== can_link_if.sv ====
// frame-level link between the network master and one node
// assumes both ends share pclk; a valid strobe lasts one cycle and is always accepted
`timescale 1ns/1ns
interface can_link_if;
    logic m2n_valid; // master frame strobe
    logic [10:0] m2n_id; // master frame identifier
    logic m2n_rtr; // remote request
    logic [3:0] m2n_len; // data length
    logic [15:0] m2n_data; // byte 0 in [7:0], byte 1 in [15:8]
    logic n2m_valid; // node frame strobe
    logic [10:0] n2m_id; // node frame identifier
    logic [7:0] n2m_data; // single data byte
    modport node (input m2n_valid, m2n_id, m2n_rtr, m2n_len, m2n_data,
                  output n2m_valid, n2m_id, n2m_data);
    modport master (output m2n_valid, m2n_id, m2n_rtr, m2n_len, m2n_data,
                    input n2m_valid, n2m_id, n2m_data);
endinterface

// ==== canopen_node.sv ====
// node end: state machine, guarding answers, life guarding and heartbeat producer
// assumes APB software access and a link whose frames are single-cycle strobes
//
// Local design decisions: the address map and the APB interface to the registers.
`timescale 1ns/1ns
module canopen_node #(
    parameter int MS_CYCLES = canopen_ec_pkg::MS_CYCLES
) (
    input wire logic pclk, // system clock
    input wire logic presetn, // asynchronous reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb write
    input wire logic [7:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // unmapped address
    output logic irq, // level interrupt
    can_link_if.node link // frame link
);
    typedef struct packed {
        canopen_ec_pkg::nmt_t nmt;
        logic [6:0] node_id;
        logic [15:0] guard_ms;
        logic [7:0] life;
        logic [15:0] hb_ms;
        logic [31:0] pre;
        logic [15:0] hb_cnt;
        logic [23:0] win_cnt;
        logic guard_on;
        logic toggle;
        logic fault;
        logic [1:0] irq_stat;
        logic [1:0] irq_en;
        logic tx_valid;
        logic [10:0] tx_id;
        logic [7:0] tx_data;
        logic [31:0] rdata;
    } node_state_t;

    node_state_t q;
    node_state_t next_q;

    // address decode
    function automatic logic mapped(input logic [7:0] a);
        mapped = (a == canopen_ec_pkg::REG_CTRL) || (a == canopen_ec_pkg::REG_GUARD) ||
                 (a == canopen_ec_pkg::REG_HB) || (a == canopen_ec_pkg::REG_STATUS) ||
                 (a == canopen_ec_pkg::REG_IRQ_STATUS) || (a == canopen_ec_pkg::REG_IRQ_CLEAR) ||
                 (a == canopen_ec_pkg::REG_IRQ_ENABLE);
    endfunction

    // apb answers in the first access cycle
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped(paddr);
    assign prdata = q.rdata;
    assign irq = |(q.irq_stat & q.irq_en);
    assign link.n2m_valid = q.tx_valid;
    assign link.n2m_id = q.tx_id;
    assign link.n2m_data = q.tx_data;

    // next-state logic
    always_comb
    begin
        logic tick;
        logic wr;
        logic guard_en;
        logic nmt_hit;
        logic rtr_hit;
        logic [1:0] ev;
        logic [1:0] clr;
        tick = 1'b0;
        wr = 1'b0;
        guard_en = 1'b0;
        nmt_hit = 1'b0;
        rtr_hit = 1'b0;
        ev = 2'h0;
        clr = 2'h0;
        next_q = q;
        next_q.tx_valid = 1'b0;
        // millisecond prescaler
        tick = (q.pre == 32'(MS_CYCLES - 1));
        next_q.pre = tick ? 32'h0 : q.pre + 32'h1;
        // read data captured in the setup cycle
        if (psel && !penable)
        begin
            unique case (paddr)
                canopen_ec_pkg::REG_CTRL: next_q.rdata = {25'h0, q.node_id};
                canopen_ec_pkg::REG_GUARD: next_q.rdata = {8'h0, q.life, q.guard_ms};
                canopen_ec_pkg::REG_HB: next_q.rdata = {16'h0, q.hb_ms};
                canopen_ec_pkg::REG_STATUS: next_q.rdata = {21'h0, q.toggle, q.fault,
                    q.guard_on, canopen_ec_pkg::hb_code(q.nmt)};
                canopen_ec_pkg::REG_IRQ_STATUS: next_q.rdata = {30'h0, q.irq_stat};
                canopen_ec_pkg::REG_IRQ_ENABLE: next_q.rdata = {30'h0, q.irq_en};
                default: next_q.rdata = 32'h0;
            endcase
        end
        // register writes take effect in the access cycle
        wr = psel && penable && pwrite;
        if (wr)
        begin
            unique case (paddr)
                canopen_ec_pkg::REG_CTRL: next_q.node_id = pwdata[6:0];
                canopen_ec_pkg::REG_GUARD:
                begin
                    next_q.guard_ms = pwdata[15:0];
                    next_q.life = pwdata[canopen_ec_pkg::GUARD_LIFE_LSB +: 8];
                end
                canopen_ec_pkg::REG_HB: next_q.hb_ms = pwdata[15:0];
                canopen_ec_pkg::REG_IRQ_CLEAR: clr = pwdata[1:0];
                canopen_ec_pkg::REG_IRQ_ENABLE: next_q.irq_en = pwdata[1:0];
                default: ;
            endcase
        end
        // leave bootup with a bootup message, no command needed
        if (q.nmt == canopen_ec_pkg::NMT_BOOT)
        begin
            next_q.nmt = canopen_ec_pkg::NMT_PREOP;
            next_q.tx_valid = 1'b1;
            next_q.tx_id = canopen_ec_pkg::ID_ERR_CTRL + {4'h0, q.node_id};
            next_q.tx_data = canopen_ec_pkg::HB_BOOT;
        end
        // management commands, node 0 addresses everyone
        nmt_hit = link.m2n_valid && !link.m2n_rtr && link.m2n_id == canopen_ec_pkg::ID_NMT &&
                  link.m2n_len == canopen_ec_pkg::NMT_LEN &&
                  (link.m2n_data[15:8] == 8'h00 || link.m2n_data[15:8] == {1'b0, q.node_id});
        if (nmt_hit && q.nmt != canopen_ec_pkg::NMT_BOOT)
        begin
            unique case (link.m2n_data[7:0])
                canopen_ec_pkg::CS_START: next_q.nmt = canopen_ec_pkg::NMT_OP;
                canopen_ec_pkg::CS_PREOP: next_q.nmt = canopen_ec_pkg::NMT_PREOP;
                canopen_ec_pkg::CS_STOP: next_q.nmt = canopen_ec_pkg::NMT_STOPPED;
                default: ;
            endcase
        end
        ev[canopen_ec_pkg::IRQ_STATE_CHG] = (next_q.nmt != q.nmt);
        // guarding only while heartbeat is off
        guard_en = q.guard_ms != 16'h0 && q.life != 8'h0 && q.hb_ms == 16'h0;
        rtr_hit = link.m2n_valid && link.m2n_rtr &&
                  link.m2n_id == canopen_ec_pkg::ID_ERR_CTRL + {4'h0, q.node_id};
        if (rtr_hit && guard_en && q.nmt != canopen_ec_pkg::NMT_BOOT)
        begin
            // answer in every state but bootup, incl. stopped
            next_q.tx_valid = 1'b1;
            next_q.tx_id = canopen_ec_pkg::ID_ERR_CTRL + {4'h0, q.node_id};
            next_q.tx_data = {q.toggle, canopen_ec_pkg::guard_code(q.nmt)};
            next_q.toggle = !q.toggle;
            next_q.guard_on = 1'b1;
            next_q.fault = 1'b0;
            next_q.win_cnt = {8'h0, q.guard_ms} * {16'h0, q.life};
        end
        else if (q.guard_on && !guard_en)
        begin
            next_q.guard_on = 1'b0;
        end
        else if (q.guard_on && tick)
        begin
            // window ran out without a request
            if (q.win_cnt <= 24'h1)
            begin
                next_q.guard_on = 1'b0;
                next_q.fault = 1'b1;
                ev[canopen_ec_pkg::IRQ_GUARD_ERR] = 1'b1;
            end
            else
            begin
                next_q.win_cnt = q.win_cnt - 24'h1;
            end
        end
        // heartbeat producer; counter at zero sends at once
        if (q.hb_ms == 16'h0)
        begin
            next_q.hb_cnt = 16'h0;
        end
        else if (q.nmt != canopen_ec_pkg::NMT_BOOT)
        begin
            if (q.hb_cnt == 16'h0)
            begin
                next_q.tx_valid = 1'b1;
                next_q.tx_id = canopen_ec_pkg::ID_ERR_CTRL + {4'h0, q.node_id};
                next_q.tx_data = canopen_ec_pkg::hb_code(q.nmt);
                next_q.hb_cnt = q.hb_ms;
            end
            else if (tick)
            begin
                next_q.hb_cnt = q.hb_cnt - 16'h1;
            end
        end
        // sticky status, a new event wins over a clear
        next_q.irq_stat = (q.irq_stat & ~clr) | ev;
    end

    // state register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            q <= '0;
            q.nmt <= canopen_ec_pkg::NMT_BOOT;
            q.node_id <= canopen_ec_pkg::NODE_ID_RESET;
            q.guard_ms <= canopen_ec_pkg::GUARD_MS_RESET;
            q.life <= canopen_ec_pkg::LIFE_RESET;
            q.hb_ms <= canopen_ec_pkg::HB_MS_RESET;
        end
        else
        begin
            q <= next_q;
        end
    end
endmodule

// ==== canopen_master.sv ====
// master end: management commands, guard polling and heartbeat consumer
// assumes one supervised node and user-side configuration held steady
`timescale 1ns/1ns
module canopen_master #(
    parameter int MS_CYCLES = canopen_ec_pkg::MS_CYCLES
) (
    input wire logic pclk, // system clock
    input wire logic presetn, // asynchronous reset, active low
    input wire logic [6:0] node_id, // supervised node
    input wire logic [15:0] poll_ms, // guard poll period, 0 off
    input wire logic [15:0] producer_ms, // node heartbeat period
    input wire logic [15:0] consumer_ms, // heartbeat timeout, 0 off
    input wire logic cmd_valid, // management command pulse
    input wire logic [7:0] cmd_spec, // command specifier
    input wire logic [6:0] cmd_node, // target node, 0 all
    output logic guard_event, // answer missing, pulse
    output logic hb_event, // heartbeat timeout, pulse
    output logic [7:0] last_answer, // last guarding answer
    can_link_if.master link // frame link
);
    typedef struct packed {
        logic [31:0] pre;
        logic [15:0] poll_cnt;
        logic poll_due;
        logic waiting;
        logic [16:0] hb_cnt;
        logic hb_on;
        logic guard_ev;
        logic hb_ev;
        logic [7:0] last;
        logic tx_valid;
        logic [10:0] tx_id;
        logic tx_rtr;
        logic [3:0] tx_len;
        logic [15:0] tx_data;
    } master_state_t;

    master_state_t q;
    master_state_t next_q;

    assign guard_event = q.guard_ev;
    assign hb_event = q.hb_ev;
    assign last_answer = q.last;
    assign link.m2n_valid = q.tx_valid;
    assign link.m2n_id = q.tx_id;
    assign link.m2n_rtr = q.tx_rtr;
    assign link.m2n_len = q.tx_len;
    assign link.m2n_data = q.tx_data;

    // next-state logic
    always_comb
    begin
        logic tick;
        logic rx_hit;
        logic [16:0] min_to;
        tick = 1'b0;
        rx_hit = 1'b0;
        min_to = 17'h0;
        next_q = q;
        next_q.tx_valid = 1'b0;
        next_q.guard_ev = 1'b0;
        next_q.hb_ev = 1'b0;
        tick = (q.pre == 32'(MS_CYCLES - 1));
        next_q.pre = tick ? 32'h0 : q.pre + 32'h1;
        // cyclic poll timer
        if (poll_ms == 16'h0)
        begin
            next_q.poll_cnt = 16'h0;
            next_q.waiting = 1'b0;
        end
        else if (q.poll_cnt == 16'h0)
        begin
            next_q.poll_due = 1'b1;
            next_q.poll_cnt = poll_ms;
        end
        else if (tick)
        begin
            next_q.poll_cnt = q.poll_cnt - 16'h1;
        end
        // commands win the link, a due poll waits one cycle
        if (cmd_valid)
        begin
            next_q.tx_valid = 1'b1;
            next_q.tx_id = canopen_ec_pkg::ID_NMT;
            next_q.tx_rtr = 1'b0;
            next_q.tx_len = canopen_ec_pkg::NMT_LEN;
            next_q.tx_data = {1'b0, cmd_node, cmd_spec};
        end
        else if (q.poll_due)
        begin
            next_q.poll_due = 1'b0;
            next_q.tx_valid = 1'b1;
            next_q.tx_id = canopen_ec_pkg::ID_ERR_CTRL + {4'h0, node_id};
            next_q.tx_rtr = 1'b1;
            next_q.tx_len = 4'h1;
            next_q.tx_data = 16'h0;
            next_q.waiting = 1'b1;
            next_q.guard_ev = q.waiting; // previous poll unanswered
        end
        // consumer timeout never shorter than producer period plus margin
        min_to = {1'b0, producer_ms} + {1'b0, canopen_ec_pkg::HB_MARGIN_MS};
        rx_hit = link.n2m_valid && link.n2m_id == canopen_ec_pkg::ID_ERR_CTRL + {4'h0, node_id};
        if (rx_hit)
        begin
            if (q.waiting)
            begin
                next_q.waiting = 1'b0;
                next_q.last = link.n2m_data;
            end
            // every indication restarts the full timeout
            next_q.hb_on = consumer_ms != 16'h0;
            next_q.hb_cnt = ({1'b0, consumer_ms} < min_to) ? min_to : {1'b0, consumer_ms};
        end
        else if (q.hb_on && tick)
        begin
            if (q.hb_cnt <= 17'h1)
            begin
                next_q.hb_on = 1'b0;
                next_q.hb_ev = 1'b1;
            end
            else
            begin
                next_q.hb_cnt = q.hb_cnt - 17'h1;
            end
        end
    end

    // state register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            q <= '0;
        end
        else
        begin
            q <= next_q;
        end
    end
endmodule

// ==== canopen_ec_sva.sv ====
// checker of the frames on the link between master and node
// assumes one pclk domain and single-cycle frame strobes
`timescale 1ns/1ns
module canopen_ec_sva (
    input wire logic pclk, // system clock
    input wire logic presetn, // reset, active low
    input wire logic m2n_valid, // master strobe
    input wire logic [10:0] m2n_id, // master id
    input wire logic m2n_rtr, // remote request
    input wire logic [3:0] m2n_len, // length
    input wire logic [15:0] m2n_data, // payload
    input wire logic n2m_valid, // node strobe
    input wire logic [10:0] n2m_id, // node id
    input wire logic [7:0] n2m_data // node byte
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // a guarding answer is a node frame right after a remote request
    sequence poll_s;
        m2n_valid && m2n_rtr;
    endsequence
    sequence answer_s;
        poll_s ##1 n2m_valid;
    endsequence
    // last toggle of an answer, and whether one was seen since reset
    logic prev_rtr;
    logic tog;
    logic seen;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prev_rtr <= 1'b0;
            tog <= 1'b0;
            seen <= 1'b0;
        end
        else
        begin
            prev_rtr <= m2n_valid && m2n_rtr;
            if (n2m_valid && prev_rtr)
            begin
                tog <= n2m_data[7];
                seen <= 1'b1;
            end
        end
    end
    a_answer_ident: assert property (n2m_valid |-> n2m_id[10:7] == 4'he)
        else $error("node frame id outside error-control range");
    a_answer_echo: assert property (answer_s |-> n2m_id == $past(m2n_id))
        else $error("answer id differs from the poll id");
    a_byte_codes: assert property (n2m_valid |->
        n2m_data inside {8'h00, 8'h04, 8'h05, 8'h7f, 8'h84, 8'h85, 8'hff})
        else $error("node frame byte is not a state code");
    a_toggle_flip: assert property (answer_s |-> n2m_data[7] == (seen ? !tog : 1'b0))
        else $error("answer toggle did not alternate");
    a_bootup_frame: assert property ($rose(presetn) |=>
        n2m_valid && n2m_data == 8'h00 && n2m_id == 11'h701)
        else $error("no bootup frame after reset");
    a_boot_once: assert property (n2m_valid && n2m_data == 8'h00 |->
        $past(presetn, 2) == 1'b0)
        else $error("bootup code sent outside bootup");
    a_cmd_shape: assert property (m2n_valid && !m2n_rtr |->
        m2n_id == 11'h000 && m2n_len == 4'h2)
        else $error("command frame id or length wrong");
    a_cmd_spec: assert property (m2n_valid && !m2n_rtr |->
        m2n_data[7:0] inside {8'h01, 8'h02, 8'h80})
        else $error("command specifier unknown");
    a_poll_ident: assert property (poll_s |-> m2n_id[10:7] == 4'he)
        else $error("poll id outside error-control range");
endmodule

// ==== test_canopen_error_control.sv ====
// testbench: master and node joined by the link, node reached over apb
// assumes both ends run with a shortened millisecond of MSC cycles
`timescale 1ns/1ns
module test_canopen_error_control;
    localparam int MSC = 10;
    localparam logic [7:0] SP[6] = '{8'h01, 8'h01, 8'h80, 8'h01, 8'h02, 8'h80};
    localparam logic [6:0] ND[6] = '{7'h03, 7'h00, 7'h05, 7'h05, 7'h05, 7'h00};
    localparam logic [6:0] EX[6] = '{7'h7f, 7'h05, 7'h7f, 7'h05, 7'h04, 7'h7f};
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err, tg;
    logic [7:0] paddr, cmd_spec, last_answer, fdata;
    logic [31:0] pwdata, prdata, rd;
    logic [6:0] node_id, cmd_node;
    logic [15:0] poll_ms, producer_ms, consumer_ms;
    logic cmd_valid, guard_event, hb_event;
    logic [10:0] fid;
    int err_count, cmp_count, fcnt, hcnt, gcnt, cyc, ftime, t0, k;
    can_link_if link();
    canopen_node #(.MS_CYCLES(MSC)) canopen_node_inst (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq), .link(link));
    canopen_master #(.MS_CYCLES(MSC)) canopen_master_inst (.pclk(pclk), .presetn(presetn),
        .node_id(node_id), .poll_ms(poll_ms), .producer_ms(producer_ms),
        .consumer_ms(consumer_ms), .cmd_valid(cmd_valid), .cmd_spec(cmd_spec),
        .cmd_node(cmd_node), .guard_event(guard_event), .hb_event(hb_event),
        .last_answer(last_answer), .link(link));
    canopen_ec_sva canopen_ec_sva_inst (.pclk(pclk), .presetn(presetn),
        .m2n_valid(link.m2n_valid), .m2n_id(link.m2n_id), .m2n_rtr(link.m2n_rtr),
        .m2n_len(link.m2n_len), .m2n_data(link.m2n_data), .n2m_valid(link.n2m_valid),
        .n2m_id(link.n2m_id), .n2m_data(link.n2m_data));
    // clock
    initial
    begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    // log of node frames and heartbeat events
    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (link.n2m_valid === 1'b1)
        begin
            fcnt <= fcnt + 1;
            ftime <= cyc;
            fdata <= link.n2m_data;
            fid <= link.n2m_id;
        end
        if (hb_event === 1'b1)
            hcnt <= hcnt + 1;
        if (guard_event === 1'b1)
            gcnt <= gcnt + 1;
    end
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        cmp_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask
    // one apb transfer; holds the request until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 20; n++)
        begin
            @(posedge pclk);
            if (pready === 1'b1)
                break;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n == 20)
        begin
            chk(0, 1, "apb timeout");
            end_of_test();
        end
    endtask
    // wait for the next node frame, bounded
    task automatic wf(input int lim);
        int s;
        s = fcnt;
        repeat (lim)
        begin
            @(posedge pclk);
            #1;
            if (fcnt != s)
                break;
        end
        if (fcnt == s)
        begin
            chk(0, 1, "no node frame");
            end_of_test();
        end
    endtask
    task automatic cmd(input logic [7:0] sp, input logic [6:0] nd);
        @(posedge pclk);
        cmd_valid <= 1'b1;
        cmd_spec <= sp;
        cmd_node <= nd;
        @(posedge pclk);
        cmd_valid <= 1'b0;
    endtask
    // main sequence
    initial
    begin
        {presetn, psel, penable, pwrite, cmd_valid} = '0;
        {paddr, pwdata, cmd_spec, cmd_node, poll_ms, producer_ms, consumer_ms} = '0;
        {err_count, cmp_count, fcnt, hcnt, gcnt, cyc, ftime} = '0;
        node_id = 7'h05;
        tg = 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        wf(5);
        chk(fid, 11'h701, "bootup id");
        chk(fdata, 8'h00, "bootup byte");
        apb(1'b0, canopen_ec_pkg::REG_STATUS, 0);
        chk(rd[10:0], 11'h0ff, "state after reset");
        apb(1'b0, canopen_ec_pkg::REG_CTRL, 0);
        chk(rd, 32'h1, "node id reset");
        apb(1'b0, 8'h1c, 0);
        chk({err, rd}, {1'b1, 32'h0}, "unmapped read");
        $display("reset test done");
        apb(1'b1, canopen_ec_pkg::REG_CTRL, 32'h5);
        apb(1'b1, canopen_ec_pkg::REG_GUARD, 32'h0003_0002);
        apb(1'b1, canopen_ec_pkg::REG_IRQ_ENABLE, 32'h1);
        poll_ms <= 16'h0002;
        wf(60);
        chk({fid, fdata}, {11'h705, tg, 7'h7f}, "first answer");
        tg = ~tg;
        for (k = 0; k < 6; k++)
        begin
            cmd(SP[k], ND[k]);
            wf(60);
            chk(fdata, {tg, EX[k]}, "answer after command");
            tg = ~tg;
        end
        chk(last_answer, {~tg, 7'h7f}, "master answer copy");
        chk(gcnt, 0, "guard event while answered");
        apb(1'b0, canopen_ec_pkg::REG_IRQ_STATUS, 0);
        chk(rd, 32'h2, "state change status");
        apb(1'b0, canopen_ec_pkg::REG_GUARD, 0);
        chk(rd, 32'h0003_0002, "guard settings");
        $display("guarding test done");
        // polls now go to another node, so this node's window runs out unanswered
        node_id <= 7'h06;
        repeat (40) @(posedge pclk);
        chk(irq, 1'b0, "early guard fault");
        repeat (30) @(posedge pclk);
        chk(irq, 1'b1, "guard fault irq");
        chk(gcnt > 0, 1'b1, "guard event on missed answer");
        apb(1'b0, canopen_ec_pkg::REG_STATUS, 0);
        chk(rd[9], 1'b1, "fault bit");
        apb(1'b1, canopen_ec_pkg::REG_IRQ_ENABLE, 32'h0);
        repeat (2) @(posedge pclk);
        chk(irq, 1'b0, "masked irq");
        apb(1'b1, canopen_ec_pkg::REG_IRQ_ENABLE, 32'h1);
        apb(1'b1, canopen_ec_pkg::REG_IRQ_CLEAR, 32'h1);
        repeat (2) @(posedge pclk);
        chk(irq, 1'b0, "cleared irq");
        node_id <= 7'h05;
        wf(60);
        chk(fdata, {tg, 7'h7f}, "answer after fault");
        apb(1'b0, canopen_ec_pkg::REG_STATUS, 0);
        chk(rd[9], 1'b0, "fault cleared");
        $display("guard fault test done");
        poll_ms <= 16'h0000;
        consumer_ms <= 16'h0004;
        producer_ms <= 16'h0003;
        apb(1'b1, canopen_ec_pkg::REG_HB, 32'h3);
        wf(5);
        chk(fdata, 8'hff, "first heartbeat");
        for (k = 0; k < 3; k++)
        begin
            t0 = ftime;
            wf(45);
            chk(ftime - t0 inside {[2 * MSC : 4 * MSC]}, 1'b1, "heartbeat gap");
        end
        chk(hcnt, 0, "timeout while fed");
        apb(1'b0, canopen_ec_pkg::REG_STATUS, 0);
        chk(rd[9:8], 2'b00, "guarding off under heartbeat");
        apb(1'b1, canopen_ec_pkg::REG_HB, 32'h0);
        t0 = fcnt;
        // bounded wait for 65 quiet cycles after the last heartbeat
        for (k = 0; k < 200 && cyc - ftime < 65; k++)
            @(posedge pclk);
        if (k == 200)
        begin
            chk(0, 1, "heartbeat did not stop");
            end_of_test();
        end
        chk(hcnt, 0, "consumer timeout clamp");
        repeat (30) @(posedge pclk);
        chk(hcnt, 1, "heartbeat event");
        chk(fcnt, t0, "heartbeat disabled");
        $display("heartbeat test done");
        end_of_test();
    end
endmodule
